// ==== src/exv_defs.svh ====
// Address, register and field constants for the exception vector unit
`ifndef EXV_DEFS_SVH
`define EXV_DEFS_SVH
`define EXV_AW 21
`define EXV_NF 18
`define EXV_ROM_END_BIG 21'h002FFF
`define EXV_ROM_END_SMALL 21'h000FFF
`define EXV_RAM_PAGE 13'h00F0
`define EXV_IO_PAGE 13'h00FF
`define EXV_SWV_LO 8'h26
`define EXV_RSVD_VEC 8'h24
`define EXV_LAST_VEC 8'h22
`define EXV_FIXED_LVL 3'h4
`define EXV_PEND_RST 18'h00001
`define EXV_NMI_TOP 2
`define EXV_OFS_CTRL 8'h00
`define EXV_OFS_STAT 8'h04
`define EXV_OFS_LVL 8'h08
`define EXV_B_OSC 0
`define EXV_B_BZC 1
`define EXV_B_BZS 2
`define EXV_B_SVDEN 3
`define EXV_B_RM 4
`define EXV_CTRL_RST 8'h08
`endif

// ==== src/exv_pkg.sv ====
// Types for the exception vector unit
package exv_pkg;
  typedef struct packed {
    logic mode_s1;
    logic mode_s2;
    logic svd_s1;
    logic svd_s2;
    logic [7:0] ctrl;
    logic [31:0] lvl;
    logic [17:0] pend;
    logic [4:0] sel;
    logic req;
    logic [7:0] vec;
    logic push;
    logic [31:0] prdata;
    logic pslverr;
    logic sel_rom;
    logic sel_ram;
    logic sel_io;
    logic sel_ext;
    logic ext_ce_b;
    logic ext_rd_b;
    logic ext_wr_b;
    logic ext_oe;
    logic sw_ok;
    logic sys_rst;
    logic heavy;
  } exv_state_s;
endpackage : exv_pkg

// ==== src/exv_top.sv ====
// Address decoder, exception vector selector and power control bits
`timescale 1ns/1ps
`include "exv_defs.svh"

module exv_top
  import exv_pkg::*;
#(
  parameter bit LARGE_ROM = 1'b1
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [`EXV_AW-1:0] cpu_addr,
  input wire logic cpu_rd,
  input wire logic cpu_wr,
  input wire logic rom_source_select_pin,
  input wire logic supply_drop_detector,
  input wire logic sleep_mode,
  input wire logic [`EXV_NF-1:1] irq_event,
  input wire logic core_ack,
  input wire logic sw_int_req,
  input wire logic [7:0] sw_int_vec,
  output logic sel_rom,
  output logic sel_ram,
  output logic sel_io,
  output logic sel_ext,
  output logic [1:0] cpu_bank,
  output logic ext_ce_b,
  output logic ext_rd_b,
  output logic ext_wr_b,
  output logic ext_data_oe,
  output logic exc_req,
  output logic [7:0] exc_vec_lo,
  output logic [7:0] exc_vec_hi,
  output logic exc_push_ctx,
  output logic sw_vec_ok,
  output logic custom_branch_flag,
  output logic heavy_load_protect,
  output logic [1:0] regulated_core_rail,
  output logic sys_reset_req
);

  exv_state_s st_reg;
  exv_state_s st_next;
  logic [2:0] eff_lvl [`EXV_NF];
  logic [`EXV_AW-1:0] rom_end;
  logic apb_wr;
  logic apb_rd;
  logic apb_setup;

  assign rom_end = LARGE_ROM ? `EXV_ROM_END_BIG : `EXV_ROM_END_SMALL;
  assign apb_wr = psel && penable && pwrite;
  // Reads and errors are decoded in setup so the answer stands at the access edge
  assign apb_setup = psel && !penable;
  assign apb_rd = apb_setup && !pwrite;

  // Effective level per factor; reset, zero divide and watchdog outrank all
  genvar gi;
  generate
    for (gi = 0; gi < `EXV_NF; gi++) begin : g_lvl
      if (gi <= `EXV_NMI_TOP) begin : g_fix
        assign eff_lvl[gi] = `EXV_FIXED_LVL;
      end else begin : g_sw
        assign eff_lvl[gi] = {1'b0, st_reg.lvl[2*(gi-1)-1 -: 2]};
      end
    end
  endgenerate

  // Next state of the whole block
  always_comb begin
    logic [`EXV_NF-1:0] ev;
    logic [2:0] best;
    logic [4:0] win;
    logic hit_rom;
    logic hit_ram;
    logic hit_io;
    logic ext;
    ev = '0;
    best = 3'h0;
    win = 5'h00;
    hit_rom = 1'b0;
    hit_ram = 1'b0;
    hit_io = 1'b0;
    ext = 1'b0;
    st_next = st_reg;
    // Straps and detector pass two flops before use
    st_next.mode_s1 = rom_source_select_pin;
    st_next.mode_s2 = st_reg.mode_s1;
    st_next.svd_s1 = supply_drop_detector;
    st_next.svd_s2 = st_reg.svd_s1;

    // Address decode; RAM and I/O win over any external device
    hit_rom = st_reg.mode_s2 && (cpu_addr <= rom_end);
    hit_ram = cpu_addr[`EXV_AW-1:8] == `EXV_RAM_PAGE;
    hit_io = cpu_addr[`EXV_AW-1:8] == `EXV_IO_PAGE;
    ext = !(hit_rom || hit_ram || hit_io);
    st_next.sel_rom = hit_rom;
    st_next.sel_ram = hit_ram;
    st_next.sel_io = hit_io;
    st_next.sel_ext = ext;
    // Strobes only for external targets, so internal cycles stay quiet
    st_next.ext_ce_b = !(ext && (cpu_rd || cpu_wr));
    st_next.ext_rd_b = !(ext && cpu_rd);
    st_next.ext_wr_b = !(ext && cpu_wr);
    st_next.ext_oe = ext && cpu_wr;

    // Software vectors: even, above the reserved slot, no ranking
    st_next.sw_ok = sw_int_req && !sw_int_vec[0] && (sw_int_vec >= `EXV_SWV_LO);

    // Supply drop forces reset when the detector option is on
    st_next.sys_rst = st_reg.svd_s2 && st_reg.ctrl[`EXV_B_SVDEN];

    // Heavy-load protect from oscillator and buzzer controls
    st_next.heavy = (st_reg.ctrl[`EXV_B_OSC] && !sleep_mode) || st_reg.ctrl[`EXV_B_BZC]
      || st_reg.ctrl[`EXV_B_BZS];

    // Events; a new event beats the clear of an acknowledge
    ev = {irq_event, st_next.sys_rst};
    if (exc_req && core_ack) begin
      st_next.pend[st_reg.sel] = 1'b0;
    end
    st_next.pend = st_next.pend | ev;

    // Highest level wins; scanning down keeps the lower table index on ties
    for (int i = `EXV_NF - 1; i >= 0; i--) begin
      if (st_next.pend[i] && eff_lvl[i] >= best) begin
        best = eff_lvl[i];
        win = 5'(i);
      end
    end
    st_next.req = |st_next.pend;
    st_next.sel = win;
    st_next.vec = {2'b00, win, 1'b0};
    st_next.push = win != 5'h00;

    // APB slave, zero wait states; unmapped offsets answer with an error
    st_next.pslverr = 1'b0;
    if (apb_wr) begin
      unique case (paddr)
        `EXV_OFS_CTRL: st_next.ctrl = pwdata[7:0];
        `EXV_OFS_LVL: st_next.lvl = pwdata;
        default: ;
      endcase
    end
    // Write error flagged in setup; status writes are ignored without error
    if (apb_setup && pwrite) begin
      unique case (paddr)
        `EXV_OFS_CTRL, `EXV_OFS_STAT, `EXV_OFS_LVL: st_next.pslverr = 1'b0;
        default: st_next.pslverr = 1'b1;
      endcase
    end
    if (apb_rd) begin
      unique case (paddr)
        `EXV_OFS_CTRL: st_next.prdata = {24'h000000, st_reg.ctrl};
        `EXV_OFS_STAT: st_next.prdata = {7'h00, st_reg.mode_s2, st_reg.sel, 1'b0, st_reg.pend};
        `EXV_OFS_LVL: st_next.prdata = st_reg.lvl;
        default: begin
          st_next.prdata = 32'h00000000;
          st_next.pslverr = 1'b1;
        end
      endcase
    end
  end

  // State register; reset leaves only the reset factor pending
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      st_reg <= '0;
      st_reg.ctrl <= `EXV_CTRL_RST;
      st_reg.pend <= `EXV_PEND_RST;
      st_reg.req <= 1'b1;
      st_reg.ext_ce_b <= 1'b1;
      st_reg.ext_rd_b <= 1'b1;
      st_reg.ext_wr_b <= 1'b1;
      st_reg.sel_ext <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs
  assign pready = 1'b1;
  assign prdata = st_reg.prdata;
  assign pslverr = st_reg.pslverr;
  assign sel_rom = st_reg.sel_rom;
  assign sel_ram = st_reg.sel_ram;
  assign sel_io = st_reg.sel_io;
  assign sel_ext = st_reg.sel_ext;
  assign cpu_bank = cpu_addr[`EXV_AW-1 -: 2];
  assign ext_ce_b = st_reg.ext_ce_b;
  assign ext_rd_b = st_reg.ext_rd_b;
  assign ext_wr_b = st_reg.ext_wr_b;
  assign ext_data_oe = st_reg.ext_oe;
  assign exc_req = st_reg.req;
  assign exc_vec_lo = st_reg.vec;
  assign exc_vec_hi = st_reg.vec | 8'h01;
  assign exc_push_ctx = st_reg.push;
  assign sw_vec_ok = st_reg.sw_ok;
  assign custom_branch_flag = 1'b0;
  assign heavy_load_protect = st_reg.heavy;
  assign regulated_core_rail = st_reg.ctrl[`EXV_B_RM +: 2];
  assign sys_reset_req = st_reg.sys_rst;

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  a_ram_inside: assert property ((cpu_addr[20:8] == 13'h00F0)
    |=> sel_ram && ext_ce_b && !ext_data_oe) else $error("RAM leaked out");
  a_io_inside: assert property ((cpu_addr[20:8] == 13'h00FF) && cpu_rd
    |=> sel_io && ext_rd_b) else $error("I/O leaked out");
  a_rom_mode: assert property (cpu_addr == 21'h0 |=> sel_rom == $past(st_reg.mode_s2))
    else $error("ROM decode wrong");
  a_ext_quiet: assert property (!sel_ext |-> ext_ce_b && ext_rd_b && ext_wr_b && !ext_data_oe)
    else $error("Strobe on internal access");
  a_vec_range: assert property (exc_req |-> exc_vec_lo <= 8'h22 && !exc_vec_lo[0]
    && exc_vec_hi == exc_vec_lo + 8'h01) else $error("Vector out of table");
  a_hold_req: assert property (exc_req && !core_ack |=> exc_req)
    else $error("Request dropped");
  a_reset_nopush: assert property (exc_req && exc_vec_lo == 8'h00 |-> !exc_push_ctx)
    else $error("Reset pushed context");
  a_zdiv_first: assert property (irq_event[1] && !st_reg.pend[0] |=> exc_vec_lo == 8'h02)
    else $error("Zero divide not first");
  a_svd_reset: assert property ($rose(st_reg.svd_s2) && st_reg.ctrl[3] |=> sys_reset_req
    ##1 exc_req && exc_vec_lo == 8'h00) else $error("No supply reset");
  a_heavy: assert property (st_reg.ctrl[1] |=> heavy_load_protect)
    else $error("Heavy load off with buzzer");
  a_sw_vec: assert property (sw_vec_ok |-> $past(sw_int_vec) >= 8'h26)
    else $error("Bad software vector");

  c_ack: cover property (exc_req && core_ack && exc_push_ctx);
  c_svd: cover property (sys_reset_req);
  c_ext: cover property (!ext_rd_b);
  c_sw: cover property (sw_vec_ok);

endmodule : exv_top

// ==== verification/exv_core_model.sv ====
// Core CPU model that takes exception requests after a set lag
`timescale 1ns/1ps
module exv_core_model
  import exv_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic exc_req,
  input wire logic [7:0] exc_vec_lo,
  input wire logic [3:0] lag,
  output logic core_ack,
  output logic taken,
  output logic [7:0] taken_vec
);
  logic [3:0] cnt;
  initial core_ack = 1'h0;
  // The core_ack term skips the stale request seen just after an ack, for any lag including zero
  always @(posedge sys_clk) begin
    core_ack <= 1'h0;
    taken <= 1'h0;
    if (!rst_b || core_ack || !exc_req) begin
      cnt <= 4'h0;
    end else if (cnt >= lag) begin
      core_ack <= 1'h1;
      taken <= 1'h1;
      taken_vec <= exc_vec_lo;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule : exv_core_model

// ==== verification/tb_exception_vector_and_memory_map.sv ====
// Self-checking bench for the exception vector and memory map unit
`timescale 1ns/1ps
module tb_exception_vector_and_memory_map
  import exv_pkg::*;
;
  logic sys_clk = 1'h0, rst_b = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic cpu_rd = 1'h0, cpu_wr = 1'h0, rom_source_select_pin = 1'h1, sleep_mode = 1'h0;
  logic supply_drop_detector = 1'h0, sw_int_req = 1'h0;
  logic [7:0] paddr = 8'h00, sw_int_vec = 8'h00, exc_vec_lo, exc_vec_hi, taken_vec;
  logic [31:0] pwdata = 32'h0, prdata, rd, er;
  logic [20:0] cpu_addr = 21'h0;
  logic [17:1] irq_event = 17'h0;
  logic [3:0] lag = 4'h1;
  logic [1:0] cpu_bank, regulated_core_rail;
  logic pready, pslverr, sel_rom, sel_ram, sel_io, sel_ext, ext_ce_b, ext_rd_b, exc_req;
  logic core_ack, taken, exc_push_ctx, sw_vec_ok, custom_branch_flag;
  logic heavy_load_protect, sys_reset_req, ext_wr_b, ext_data_oe;
  int bad_count = 0, samples_checked = 0;
  // Address, expected {rom, ram, io, ext, ce_b, rd_b, bank}
  logic [28:0] dtab [7] = '{{21'h002FFF, 8'h8C}, {21'h003000, 8'h10}, {21'h00F000, 8'h4C},
    {21'h00F0FF, 8'h4C}, {21'h00FF00, 8'h2C}, {21'h00FFFF, 8'h2C}, {21'h180000, 8'h13}};
  // Sleep, expected protect, control bits
  logic [7:0] htab [6] = '{8'h49, 8'h89, 8'hCA, 8'h4C, 8'h18, 8'hB8};
  // Accepted flag, proposed software vector
  logic [8:0] stab [6] = '{9'h126, 9'h1FE, 9'h180, 9'h024, 9'h027, 9'h022};

  always #2.5 sys_clk = ~sys_clk;

  exv_top #(.LARGE_ROM(1'h1)) DUT (.sys_clk, .rst_b, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .cpu_addr, .cpu_rd, .cpu_wr, .rom_source_select_pin,
    .supply_drop_detector, .sleep_mode, .irq_event, .core_ack, .sw_int_req, .sw_int_vec,
    .sel_rom, .sel_ram, .sel_io, .sel_ext, .cpu_bank, .ext_ce_b, .ext_rd_b, .ext_wr_b,
    .ext_data_oe, .exc_req, .exc_vec_lo, .exc_vec_hi, .exc_push_ctx, .sw_vec_ok,
    .custom_branch_flag, .heavy_load_protect, .regulated_core_rail, .sys_reset_req);
  exv_core_model CPU (.sys_clk, .rst_b, .exc_req, .exc_vec_lo, .lag, .core_ack, .taken,
    .taken_vec);

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize

  task automatic bump();
    bad_count++;
    summarize();
  endtask : bump

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Setup, access held until pready; answer taken at that same edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    rd = prdata;
    er = {31'h0, pslverr};
    psel <= 1'h0;
    penable <= 1'h0;
    if (n >= 20) bump();
  endtask : apb

  // Waits for the core to take a request; vector pair sampled at that edge
  task automatic take(input logic [7:0] v);
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (taken !== 1'h1 && n < 60);
    if (n >= 60) begin
      bump();
    end else begin
      chk(taken_vec, v);
      chk(exc_vec_hi, v + 8'h01);
      chk(exc_push_ctx, v != 8'h00);
    end
  endtask : take

  // Strap changes only under reset; reset factor must come out first
  task automatic do_reset(input logic pin);
    @(posedge sys_clk);
    rst_b <= 1'h0;
    rom_source_select_pin <= pin;
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'h1;
    take(8'h00);
    repeat (3) @(posedge sys_clk);
  endtask : do_reset

  task automatic dec(input logic [20:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    cpu_addr <= a;
    cpu_rd <= 1'h1;
    repeat (2) @(posedge sys_clk);
    chk({sel_rom, sel_ram, sel_io, sel_ext, ext_ce_b, ext_rd_b, cpu_bank}, e);
    cpu_rd <= 1'h0;
  endtask : dec

  // Write cycle: expected {wr_b, data_oe}
  task automatic decw(input logic [20:0] a, input logic [1:0] e);
    @(posedge sys_clk);
    cpu_addr <= a;
    cpu_wr <= 1'h1;
    repeat (2) @(posedge sys_clk);
    chk({ext_wr_b, ext_data_oe}, e);
    cpu_wr <= 1'h0;
  endtask : decw

  task automatic fire(input logic [17:1] m);
    @(posedge sys_clk);
    irq_event <= m;
    @(posedge sys_clk);
    irq_event <= 17'h0;
  endtask : fire

  // Main sequence
  initial begin
    do_reset(1'h1);
    chk(custom_branch_flag, 1'h0);
    apb(1'h0, 8'h00, 32'h0);
    chk(rd, 32'h8);
    apb(1'h0, 8'h0C, 32'h0);
    chk(er, 32'h1);
    foreach (dtab[i]) dec(dtab[i][28:8], dtab[i][7:0]);
    decw(21'h003000, 2'h1);
    decw(21'h00F000, 2'h2);
    foreach (htab[i]) begin
      sleep_mode <= htab[i][7];
      apb(1'h1, 8'h00, {26'h0, htab[i][5:0]});
      repeat (2) @(posedge sys_clk);
      chk(heavy_load_protect, htab[i][6]);
      chk(regulated_core_rail, htab[i][5:4]);
      apb(1'h0, 8'h00, 32'h0);
      chk(rd, {26'h0, htab[i][5:0]});
    end
    foreach (stab[i]) begin
      @(posedge sys_clk);
      sw_int_req <= 1'h1;
      sw_int_vec <= stab[i][7:0];
      @(posedge sys_clk);
      sw_int_req <= 1'h0;
      @(posedge sys_clk);
      chk(sw_vec_ok, stab[i][8]);
    end
    // Slow core, factors 1 to 17 at once, equal programmable levels
    apb(1'h1, 8'h08, 32'h0);
    lag <= 4'h6;
    fire(17'h1FFFF);
    for (int i = 1; i < 18; i++) take(8'(2 * i));
    lag <= 4'h1;
    apb(1'h1, 8'h08, 32'hC000_0000);
    fire(17'h18000);
    take(8'h22);
    take(8'h20);
    fire(17'h10002);
    take(8'h04);
    take(8'h22);
    // Long lag so the drop is seen before the core takes it
    lag <= 4'hF;
    supply_drop_detector <= 1'h1;
    repeat (4) @(posedge sys_clk);
    chk(sys_reset_req, 1'h1);
    supply_drop_detector <= 1'h0;
    take(8'h00);
    do_reset(1'h0);
    dec(21'h000000, 8'h10);
    dec(21'h00F010, 8'h4C);
    summarize();
  end
endmodule : tb_exception_vector_and_memory_map
